// ---- hdl/ivp_interrupt_vector_priority.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Flags one: external pin..timer b ch0 in bits 2-7, bits 1:0 zero, reset zero.
// - Flags two: timer b ch1 (bit 0) up to keyboard (bit 7), read-only, reset zero.
// - Flags three: converter bit 0, timebase bit 1, spares 2-5, 7:6 zero.
// - Converter request vectors at FFDE/FFDF, just above timebase.
// - Serial transmit vectors at FFE2/FFE3, above keyboard.
// - Serial receive vectors at FFE4/FFE5, above serial transmit.
// - Serial error vectors at FFE6/FFE7, above serial receive.
// - SPI transmit vectors at FFE8/FFE9, above serial error.
// - SPI receive vectors at FFEA/FFEB, above SPI transmit.
// - Timer b overflow vectors at FFEC/FFED, above SPI receive.
// - Timer b channel 1 vectors at FFEE/FFEF, above timer b overflow.
// - Timer b channel 0 vectors at FFF0/FFF1, above timer b channel 1.
// - Timer a overflow vectors at FFF2/FFF3, above timer b channel 0.
// - Timer a channel 1 vectors at FFF4/FFF5, above timer a overflow.
// - Timer a channel 0 vectors at FFF6/FFF7, above timer a channel 1.
module ivp_interrupt_vector_priority
  import ivp_pkg::*;
#(
  parameter int NUM_SRC = IVP_NUM_SRC
)
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [15:0]       address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  output logic      [1:0]        response,
  input  wire logic [NUM_SRC-1:0] sourceFlags,
  input  wire logic              swTrapReq,
  input  wire logic              resetReq,
  output logic                   irqPending,
  output logic      [15:0]       vectorAddr,
  output logic      [4:0]        vectorSource,
  output logic                   vectorValid,
  output logic                   irq
);

  initial
  begin
    if (NUM_SRC != IVP_NUM_SRC)
      $error("NUM_SRC must be 20");
  end

  logic [NUM_SRC-1:0] flags_reg;
  logic [NUM_SRC-1:0] enable_reg;
  logic [1:0]         evtStatus_reg;
  logic [1:0]         evtMask_reg;
  logic [15:0]        vector_reg;
  logic [4:0]         source_reg;
  logic               valid_reg;
  logic [31:0]        readdata_reg;
  logic [1:0]         response_reg;
  logic               ack_reg;
  logic [1:0]         evtSet;
  logic [NUM_SRC-1:0] newActive;
  ivp_req_t           req;
  ivp_vec_sel_t       sel;
  logic [15:0]        wordIdx;
  logic               access;

  assign access  = (read | write) & ~ack_reg;
  // Index bits 15:14 lie above a 16-bit byte address; every register index has them set
  assign wordIdx = {2'b11, address[15:2]};

  // Flag words are sampled every cycle so software sees the pending state one cycle later
  always_ff @(posedge clock)
  begin
    if (!rstn)
      flags_reg <= {NUM_SRC{1'b0}};
    else
      flags_reg <= sourceFlags;
  end

  assign req = '{reset: resetReq, trap: swTrapReq, flags: flags_reg};

  ivp_priority_encoder #(
    .NUM_SRC (NUM_SRC)
  ) u_encoder (
    .req    (req),
    .enable (enable_reg),
    .sel    (sel)
  );

  // Registered vector output; held at the reset vector while nothing is selected
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      vector_reg <= IVP_RST_VECTOR;
      source_reg <= 5'h00;
      valid_reg  <= 1'b0;
    end
    else
    begin
      vector_reg <= sel.vector;
      source_reg <= sel.source;
      valid_reg  <= sel.valid;
    end
  end

  assign vectorAddr   = vector_reg;
  assign vectorSource = source_reg;
  assign vectorValid  = valid_reg;
  assign irqPending   = valid_reg;

  // Events: vector change, newly pending enabled flag
  assign newActive = sourceFlags & ~flags_reg & enable_reg;
  assign evtSet[IVP_EVT_VEC_CHANGE] = sel.vector != vector_reg;
  assign evtSet[IVP_EVT_NEW_REQ]    = |newActive;

  // Enable registers
  always_ff @(posedge clock)
  begin
    if (!rstn)
      enable_reg <= IVP_RST_ENABLE;
    else if (access && write)
    begin
      if (wordIdx == IVP_IDX_REQ_ENABLE)
      begin
        for (int b = 0; b < 2; b++)
          if (byteenable[b])
            enable_reg[b*8 +: 8] <= writedata[b*8 +: 8];
      end
      else if (wordIdx == IVP_IDX_REQ_ENABLE2 && byteenable[0])
        enable_reg[19:16] <= writedata[3:0];
    end
  end

  // Sticky event status: set wins over write-one-to-clear
  always_ff @(posedge clock)
  begin
    if (!rstn)
      evtStatus_reg <= IVP_RST_EVT;
    else if (access && write && wordIdx == IVP_IDX_EVT_STATUS && byteenable[0])
      evtStatus_reg <= (evtStatus_reg & ~writedata[1:0]) | evtSet;
    else
      evtStatus_reg <= evtStatus_reg | evtSet;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      evtMask_reg <= IVP_RST_EVT;
    else if (access && write && wordIdx == IVP_IDX_EVT_MASK && byteenable[0])
      evtMask_reg <= writedata[1:0];
  end

  assign irq = |(evtStatus_reg & evtMask_reg);

  // Bus slave: one wait state, answer at the second edge of the request
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h00000000;
      response_reg <= 2'h0;
    end
    else
    begin
      ack_reg <= access;
      if (access)
      begin
        response_reg <= 2'h0;
        readdata_reg <= 32'h00000000;
        if (wordIdx == IVP_IDX_FLAGS_ONE)
        begin
          readdata_reg[7:2] <= flags_reg[5:0];
          if (write)
            response_reg <= 2'h2;
        end
        else if (wordIdx == IVP_IDX_FLAGS_TWO)
        begin
          readdata_reg[7:0] <= flags_reg[13:6];
          if (write)
            response_reg <= 2'h2;
        end
        else if (wordIdx == IVP_IDX_FLAGS_THREE)
        begin
          // Converter sits in bit 0, timebase in bit 1
          readdata_reg[0]   <= flags_reg[14];
          readdata_reg[1]   <= flags_reg[15];
          readdata_reg[5:2] <= flags_reg[19:16];
          if (write)
            response_reg <= 2'h2;
        end
        else if (wordIdx == IVP_IDX_EVT_STATUS)
          readdata_reg[1:0] <= evtStatus_reg;
        else if (wordIdx == IVP_IDX_EVT_MASK)
          readdata_reg[1:0] <= evtMask_reg;
        else if (wordIdx == IVP_IDX_REQ_ENABLE)
          readdata_reg[15:0] <= enable_reg[15:0];
        else if (wordIdx == IVP_IDX_REQ_ENABLE2)
          readdata_reg[3:0] <= enable_reg[19:16];
        else if (wordIdx == IVP_IDX_VECTOR)
          readdata_reg <= {11'h000, source_reg, vector_reg};
        else
          response_reg <= 2'h2;
      end
    end
  end

  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata    = readdata_reg;
  assign response    = response_reg;

endmodule

// ---- hdl/ivp_pkg.sv ----
package ivp_pkg;

  // Register word indices; byte address = 4 * index, upper two index bits implied
  localparam logic [15:0] IVP_IDX_FLAGS_ONE   = 16'hFE04;
  localparam logic [15:0] IVP_IDX_FLAGS_TWO   = 16'hFE05;
  localparam logic [15:0] IVP_IDX_FLAGS_THREE = 16'hFE06;
  localparam logic [15:0] IVP_IDX_EVT_STATUS  = 16'hFE10;
  localparam logic [15:0] IVP_IDX_EVT_MASK    = 16'hFE11;
  localparam logic [15:0] IVP_IDX_REQ_ENABLE  = 16'hFE12;
  localparam logic [15:0] IVP_IDX_VECTOR      = 16'hFE13;
  localparam logic [15:0] IVP_IDX_REQ_ENABLE2 = 16'hFE14;

  localparam int IVP_NUM_SRC = 20;

  // Source positions in the 20-bit flag word (index 0 = external pin ... 19 = spare d)
  localparam int IVP_SRC_EXT_PIN   = 0;
  localparam int IVP_SRC_TIMEBASE  = 15;

  // Vector addresses, high byte address of each pair
  localparam logic [15:0] IVP_VEC_TIMEBASE  = 16'hFFDC;
  localparam logic [15:0] IVP_VEC_CONVERTER = 16'hFFDE;
  localparam logic [15:0] IVP_VEC_KEYBOARD  = 16'hFFE0;
  localparam logic [15:0] IVP_VEC_SER_TX    = 16'hFFE2;
  localparam logic [15:0] IVP_VEC_SER_RX    = 16'hFFE4;
  localparam logic [15:0] IVP_VEC_SER_ERR   = 16'hFFE6;
  localparam logic [15:0] IVP_VEC_SPI_TX    = 16'hFFE8;
  localparam logic [15:0] IVP_VEC_SPI_RX    = 16'hFFEA;
  localparam logic [15:0] IVP_VEC_TB_OVF    = 16'hFFEC;
  localparam logic [15:0] IVP_VEC_TB_CH1    = 16'hFFEE;
  localparam logic [15:0] IVP_VEC_TB_CH0    = 16'hFFF0;
  localparam logic [15:0] IVP_VEC_TA_OVF    = 16'hFFF2;
  localparam logic [15:0] IVP_VEC_TA_CH1    = 16'hFFF4;
  localparam logic [15:0] IVP_VEC_TA_CH0    = 16'hFFF6;
  localparam logic [15:0] IVP_VEC_CLK_GEN   = 16'hFFF8;
  localparam logic [15:0] IVP_VEC_EXT_PIN   = 16'hFFFA;
  localparam logic [15:0] IVP_VEC_SW_TRAP   = 16'hFFFC;
  localparam logic [15:0] IVP_VEC_RESET     = 16'hFFFE;

  localparam logic [7:0]  IVP_RST_FLAGS  = 8'h00;
  localparam logic [19:0] IVP_RST_ENABLE = 20'h00000;
  localparam logic [1:0]  IVP_RST_EVT    = 2'h0;
  localparam logic [15:0] IVP_RST_VECTOR = 16'hFFFE;

  // Event status bit positions
  localparam int IVP_EVT_VEC_CHANGE = 0;
  localparam int IVP_EVT_NEW_REQ    = 1;

  typedef enum logic [1:0] {IVP_SEL_NONE, IVP_SEL_RESET, IVP_SEL_TRAP, IVP_SEL_SOURCE} ivp_sel_kind_t;

  typedef struct packed {
    logic          valid;
    ivp_sel_kind_t kind;
    logic [4:0]    source;
    logic [15:0]   vector;
  } ivp_vec_sel_t;

  typedef struct packed {
    logic        reset;
    logic        trap;
    logic [19:0] flags;
  } ivp_req_t;

endpackage

// ---- hdl/ivp_priority_encoder.sv ----
`timescale 1ns/10ps
module ivp_priority_encoder
  import ivp_pkg::*;
#(
  parameter int NUM_SRC = IVP_NUM_SRC
)
(
  input  ivp_req_t     req,
  input  wire logic [NUM_SRC-1:0] enable,
  output ivp_vec_sel_t sel
);

  initial
  begin
    if (NUM_SRC != IVP_NUM_SRC)
      $error("NUM_SRC must match the vector table size");
  end

  function automatic logic [15:0] srcVector(input logic [4:0] idx);
    logic [15:0] v;
    v = IVP_VEC_TIMEBASE;
    case (idx)
      5'h00: v = IVP_VEC_EXT_PIN;
      5'h01: v = IVP_VEC_CLK_GEN;
      5'h02: v = IVP_VEC_TA_CH0;
      5'h03: v = IVP_VEC_TA_CH1;
      5'h04: v = IVP_VEC_TA_OVF;
      5'h05: v = IVP_VEC_TB_CH0;
      5'h06: v = IVP_VEC_TB_CH1;
      5'h07: v = IVP_VEC_TB_OVF;
      5'h08: v = IVP_VEC_SPI_RX;
      5'h09: v = IVP_VEC_SPI_TX;
      5'h0A: v = IVP_VEC_SER_ERR;
      5'h0B: v = IVP_VEC_SER_RX;
      5'h0C: v = IVP_VEC_SER_TX;
      5'h0D: v = IVP_VEC_KEYBOARD;
      5'h0E: v = IVP_VEC_CONVERTER;
      default: v = IVP_VEC_TIMEBASE;
    endcase
    return v;
  endfunction

  logic [NUM_SRC-1:0] active;

  assign active = req.flags & enable;

  always_comb
  begin
    sel = '{valid: 1'b0, kind: IVP_SEL_NONE, source: 5'h00, vector: IVP_RST_VECTOR};
    if (req.reset)
    begin
      sel = '{valid: 1'b1, kind: IVP_SEL_RESET, source: 5'h00, vector: IVP_VEC_RESET};
    end
    else if (req.trap)
    begin
      sel = '{valid: 1'b1, kind: IVP_SEL_TRAP, source: 5'h00, vector: IVP_VEC_SW_TRAP};
    end
    else
    begin
      // Scan from the lowest rank upward so the highest-ranked pending source wins
      for (int i = IVP_SRC_TIMEBASE; i >= IVP_SRC_EXT_PIN; i--)
      begin
        if (active[i])
        begin
          sel.valid  = 1'b1;
          sel.kind   = IVP_SEL_SOURCE;
          sel.source = 5'(i);
          sel.vector = srcVector(5'(i));
        end
      end
    end
  end

endmodule

// ---- tb/ivp_core_model.sv ----
`timescale 1ns/10ps
module ivp_core_model
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        vectorValid,
  input  wire logic [15:0] vectorAddr,
  output logic      [15:0] fetchAddr
);
  // Core fetches the high byte address; low byte follows at +1
  always_ff @(posedge clock)
    if (!rstn) fetchAddr <= 16'hFFFE;
    else if (vectorValid) fetchAddr <= vectorAddr;
endmodule

// ---- tb/ivp_interrupt_vector_priority_sva.sv ----
`timescale 1ns/10ps
module ivp_interrupt_vector_priority_sva
  import ivp_pkg::*;
#(
  parameter int NUM_SRC = IVP_NUM_SRC
)
(
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic [15:0]        address,
  input wire logic               read,
  input wire logic               write,
  input wire logic               waitrequest,
  input wire logic [1:0]         response,
  input wire logic [NUM_SRC-1:0] sourceFlags,
  input wire logic               swTrapReq,
  input wire logic               resetReq,
  input wire logic               irqPending,
  input wire logic [15:0]        vectorAddr,
  input wire logic [4:0]         vectorSource,
  input wire logic               vectorValid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  chk_reset_vector_wins:
    assert property (resetReq [*3] |-> vectorAddr == IVP_VEC_RESET) else $error("reset vector missing");
  chk_trap_vector:
    assert property ((swTrapReq && !resetReq) [*3] |-> vectorAddr == IVP_VEC_SW_TRAP) else $error("trap vector missing");
  chk_source_vector_map:
    assert property (vectorValid && vectorAddr < 16'hFFFC && vectorSource < 5'h10
      |-> vectorAddr == 16'hFFFA - {10'h000, vectorSource, 1'b0}) else $error("vector does not fit source");
  chk_idle_vector:
    assert property ((sourceFlags == '0 && !swTrapReq && !resetReq) [*3]
      |-> !vectorValid && vectorAddr == IVP_VEC_RESET) else $error("vector without request");
  chk_pending_valid:
    assert property (irqPending == vectorValid) else $error("pending differs from valid");
  chk_wait_first:
    assert property ($rose(read) || $rose(write) |-> waitrequest) else $error("no wait state");
  chk_wait_once:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait state too long");
  chk_flags_read_only:
    assert property (write && !waitrequest && address[15:2] >= IVP_IDX_FLAGS_ONE[13:0]
      && address[15:2] <= IVP_IDX_FLAGS_THREE[13:0] |-> response == 2'h2) else $error("flag write accepted");
  cov_trap: cover property (swTrapReq && vectorAddr == IVP_VEC_SW_TRAP);
  cov_timebase: cover property (vectorValid && vectorAddr == IVP_VEC_TIMEBASE);
  cov_write: cover property (write && !waitrequest);
endmodule
bind ivp_interrupt_vector_priority ivp_interrupt_vector_priority_sva #(.NUM_SRC(NUM_SRC)) ivp_sva_i (.clock, .rstn,
  .address, .read, .write, .waitrequest, .response, .sourceFlags, .swTrapReq, .resetReq, .irqPending, .vectorAddr,
  .vectorSource, .vectorValid);

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import ivp_pkg::*;
;
  logic        clock, rstn, read, write, waitrequest, swTrapReq, resetReq, irqPending, vectorValid, irq;
  logic [15:0] address, vectorAddr, fetchAddr;
  logic [31:0] writedata, readdata, rdat;
  logic [19:0] sourceFlags, f;
  logic [4:0]  vectorSource;
  logic [1:0]  response, rsp;
  int          mismatches, comparisons;
  logic [15:0] vecTab [16] = '{IVP_VEC_EXT_PIN, IVP_VEC_CLK_GEN, IVP_VEC_TA_CH0, IVP_VEC_TA_CH1, IVP_VEC_TA_OVF,
    IVP_VEC_TB_CH0, IVP_VEC_TB_CH1, IVP_VEC_TB_OVF, IVP_VEC_SPI_RX, IVP_VEC_SPI_TX, IVP_VEC_SER_ERR, IVP_VEC_SER_RX,
    IVP_VEC_SER_TX, IVP_VEC_KEYBOARD, IVP_VEC_CONVERTER, IVP_VEC_TIMEBASE};
  ivp_interrupt_vector_priority ivp_interrupt_vector_priority_i (.clock(clock), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .sourceFlags(sourceFlags), .swTrapReq(swTrapReq),
    .resetReq(resetReq), .irqPending(irqPending), .vectorAddr(vectorAddr), .vectorSource(vectorSource),
    .vectorValid(vectorValid), .irq(irq));
  ivp_core_model ivp_core_model_i (.clock(clock), .rstn(rstn), .vectorValid(vectorValid), .vectorAddr(vectorAddr),
    .fetchAddr(fetchAddr));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Answer taken at the rising edge where waitrequest is sampled low; only the watchdog ends a wait
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= {idx[13:0], 2'b00};
    writedata <= d;
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    rdat = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic apply(input logic [19:0] v, input logic t, input logic r);
    @(posedge clock);
    sourceFlags <= v;
    swTrapReq <= t;
    resetReq <= r;
    repeat (3) @(negedge clock);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_layout();
    f = 20'hC5A3D;
    apply(f, 1'b0, 1'b0);
    bus(1'b0, IVP_IDX_FLAGS_ONE, 32'h0);
    check("flags one", rdat, {24'h0, f[5:0], 2'b00});
    bus(1'b1, IVP_IDX_FLAGS_TWO, 32'hFF);
    check("flags two write", {30'h0, rsp}, 32'h2);
    bus(1'b0, IVP_IDX_FLAGS_TWO, 32'h0);
    check("flags two", rdat, {24'h0, f[13:6]});
    bus(1'b0, IVP_IDX_FLAGS_THREE, 32'h0);
    check("flags three", rdat, {26'h0, f[19:14]});
    bus(1'b0, 16'h0000, 32'h0);
    check("unmapped", {rdat[29:0], rsp}, 32'h2);
  endtask
  task automatic t_vectors();
    bus(1'b1, IVP_IDX_REQ_ENABLE, 32'hFFFE);
    apply(20'h00003, 1'b0, 1'b0);
    check("disabled loses", vectorAddr, IVP_VEC_CLK_GEN);
    bus(1'b1, IVP_IDX_REQ_ENABLE, 32'hFFFF);
    bus(1'b1, IVP_IDX_REQ_ENABLE2, 32'hF);
    for (int i = 0; i < 16; i++)
    begin
      apply(20'h1 << i, 1'b0, 1'b0);
      check("single vector", {vectorSource, vectorAddr}, {i[4:0], vecTab[i]});
      apply(20'hFFFFF << i, 1'b0, 1'b0);
      check("ranked vector", vectorAddr, vecTab[i]);
    end
    bus(1'b0, IVP_IDX_VECTOR, 32'h0);
    check("vector word", rdat, {11'h000, 5'h0F, IVP_VEC_TIMEBASE});
    bus(1'b0, IVP_IDX_REQ_ENABLE2, 32'h0);
    check("enable high", rdat, 32'h0000000F);
  endtask
  task automatic t_trap_irq();
    apply(20'hFFFFF, 1'b1, 1'b0);
    check("trap", {fetchAddr, vectorAddr}, {2{IVP_VEC_SW_TRAP}});
    check("trap pending", irqPending, 1'b1);
    apply(20'hFFFFF, 1'b1, 1'b1);
    check("reset", vectorAddr, IVP_VEC_RESET);
    bus(1'b0, IVP_IDX_EVT_STATUS, 32'h0);
    check("change event", {rdat[1:0], irq}, 32'h6);
    bus(1'b1, IVP_IDX_EVT_MASK, 32'h3);
    @(negedge clock);
    check("irq raised", irq, 1'b1);
    bus(1'b1, IVP_IDX_EVT_STATUS, 32'h3);
    @(negedge clock);
    check("irq cleared", irq, 1'b0);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    {rstn, read, write, swTrapReq, resetReq, address, writedata, sourceFlags} = '0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    check("reset vector", {vectorValid, vectorAddr}, {1'b0, IVP_RST_VECTOR});
    bus(1'b0, IVP_IDX_FLAGS_ONE, 32'h0);
    check("flags one reset", rdat, 32'h0);
    t_layout();
    t_vectors();
    t_trap_irq();
    give_verdict();
  end
endmodule
